//--- logic/ccvc_pkg.sv
`default_nettype none

package ccvc_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [7:0] CCVC_ADDR_FAST_CURRENT = 8'h1C;
  localparam logic [7:0] CCVC_ADDR_TEMP_CURRENT = 8'h1D;
  localparam logic [7:0] CCVC_ADDR_VOLT_SUSPEND = 8'h1E;
  localparam logic [7:0] CCVC_ADDR_TEMP_VOLTAGE = 8'h1F;
  localparam logic [7:0] CCVC_RST_FAST_CURRENT = 8'h05;
  localparam logic [7:0] CCVC_RST_TEMP_CURRENT = 8'h04;
  localparam logic [7:0] CCVC_RST_VOLT_SUSPEND = 8'h00;
  localparam logic [7:0] CCVC_RST_TEMP_VOLTAGE = 8'h00;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int CCVC_CODE_MSB = 7;
  localparam int CCVC_CODE_LSB = 2;
  localparam int CCVC_THERM_BIT = 1;
  localparam int CCVC_SUSPEND_BIT = 1;
  localparam int CCVC_RSVD_BIT = 0;
  localparam logic [1:0] CCVC_INPUT_DETAIL_OFF = 2'h0;

  // ---------------------------------------------------------------
  // Code tables
  // ---------------------------------------------------------------
  // Current in units of 0.1 mA: 75 per step, saturating at code 0x27.
  localparam logic [11:0] CCVC_CURRENT_STEP = 12'h04B;
  localparam logic [5:0] CCVC_CURRENT_SAT_CODE = 6'h27;
  localparam logic [11:0] CCVC_CURRENT_MAX = 12'hBB8;
  // Voltage in mV: 3600 plus 25 per step, saturating at 4600.
  localparam logic [12:0] CCVC_VOLT_BASE = 13'h0E10;
  localparam logic [12:0] CCVC_VOLT_STEP = 13'h0019;
  localparam logic [5:0] CCVC_VOLT_SAT_CODE = 6'h28;
  localparam logic [12:0] CCVC_VOLT_MAX = 13'h11F8;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } ccvc_req_t;

  typedef struct packed {
    logic [11:0] current_0p1ma;
    logic [12:0] voltage_mv;
    logic thermistor_bias;
    logic input_suspend;
  } ccvc_drive_t;

endpackage

`default_nettype wire

//--- logic/ccvc_code_map.sv
`timescale 1ns/1ns
`default_nettype none

// Registered decode of one current or voltage code.
module ccvc_code_map
  import ccvc_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [5:0] code,
  output logic [11:0] current_0p1ma,
  output logic [12:0] voltage_mv
);

  logic [11:0] next_current_0p1ma;
  logic [12:0] next_voltage_mv;
  logic [17:0] cur_prod;
  logic [18:0] volt_prod;

  always_comb
  begin
    cur_prod = 18'({6'h00, code} + 12'h001) * 18'(CCVC_CURRENT_STEP);
    volt_prod = 19'(code) * 19'(CCVC_VOLT_STEP);
    if (code >= CCVC_CURRENT_SAT_CODE)
    begin
      next_current_0p1ma = CCVC_CURRENT_MAX;
    end
    else
    begin
      next_current_0p1ma = cur_prod[11:0];
    end
    if (code >= CCVC_VOLT_SAT_CODE)
    begin
      next_voltage_mv = CCVC_VOLT_MAX;
    end
    else
    begin
      next_voltage_mv = CCVC_VOLT_BASE + volt_prod[12:0];
    end
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      current_0p1ma <= 12'h000;
      voltage_mv <= 13'h0000;
    end
    else
    begin
      current_0p1ma <= next_current_0p1ma;
      voltage_mv <= next_voltage_mv;
    end
  end

endmodule

`default_nettype wire

//--- logic/ccvc_regs.sv
// Notes on behaviour
// - Current code gives 7.5mA times (code+1); 0x27 and above give 300mA.
// - Compensated current 0x1D[7:2] applies only when battery is cool or warm.
// - Thermistor enable 0 keeps bias off and ignores temperature.
// - Thermistor enable 1 turns bias on and uses temperature.
// - Register 0x1E[7:2] is voltage code, 3.6V plus 25mV steps, max 4.6V.
// - Suspend bit 0 leaves charger input free to draw current.
// - Suspend bit 1 suspends charger input, drawing no current.
// - Setting suspend raises input change interrupt and forces detail 0b00.
// - Register 0x1D resets to 0x04 on system reset.
// - 0x1E voltage bits clear on system reset, others on charger POR.
// - Normal current 0x1C[7:2] uses the same current mapping.
// - Compensated voltage 0x1F replaces normal voltage only when cool or warm.
`timescale 1ns/1ns
`default_nettype none

module ccvc_regs
  import ccvc_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic system_reset,
  input wire logic charger_power_on_reset,
  input wire ccvc_req_t req,
  input wire logic cool_threshold,
  input wire logic warm_threshold,
  input wire logic [1:0] input_detail_raw,
  output logic [7:0] rdata,
  output logic rvalid,
  output logic input_change_interrupt,
  output logic [1:0] input_detail_status,
  output logic temp_qualified,
  output ccvc_drive_t drive
);

  // -------------------------------------------------------------
  // Register storage
  // -------------------------------------------------------------
  logic [7:0] fast_charge_current_reg;
  logic [7:0] temp_current_reg;
  logic [5:0] fast_charge_voltage;
  logic input_suspend;
  logic rsvd_bit;
  logic [7:0] temp_voltage_reg;
  logic [7:0] next_fast_charge_current_reg;
  logic [7:0] next_temp_current_reg;
  logic [5:0] next_fast_charge_voltage;
  logic next_input_suspend;
  logic next_rsvd_bit;
  logic [7:0] next_temp_voltage_reg;
  logic [7:0] next_rdata;
  logic next_rvalid;
  logic next_input_change_interrupt;
  logic [1:0] next_input_detail_status;
  logic next_temp_qualified;
  logic thermistor_enable;
  logic temp_region;
  logic [5:0] sel_current_code;
  logic [5:0] sel_voltage_code;
  logic [11:0] map_current;
  logic [12:0] map_voltage;
  logic wr_fast;
  logic wr_tcur;
  logic wr_vs;
  logic wr_tvolt;

  assign thermistor_enable = temp_current_reg[CCVC_THERM_BIT];
  assign wr_fast = req.wr && (req.addr == CCVC_ADDR_FAST_CURRENT);
  assign wr_tcur = req.wr && (req.addr == CCVC_ADDR_TEMP_CURRENT);
  assign wr_vs = req.wr && (req.addr == CCVC_ADDR_VOLT_SUSPEND);
  assign wr_tvolt = req.wr && (req.addr == CCVC_ADDR_TEMP_VOLTAGE);

  // -------------------------------------------------------------
  // Write path
  // -------------------------------------------------------------
  always_comb
  begin
    next_fast_charge_current_reg = fast_charge_current_reg;
    next_temp_current_reg = temp_current_reg;
    next_fast_charge_voltage = fast_charge_voltage;
    next_input_suspend = input_suspend;
    next_rsvd_bit = rsvd_bit;
    next_temp_voltage_reg = temp_voltage_reg;
    if (wr_fast)
    begin
      next_fast_charge_current_reg = req.wdata;
    end
    if (wr_tcur)
    begin
      next_temp_current_reg = req.wdata;
    end
    if (wr_vs)
    begin
      next_fast_charge_voltage = req.wdata[CCVC_CODE_MSB:CCVC_CODE_LSB];
      next_input_suspend = req.wdata[CCVC_SUSPEND_BIT];
      next_rsvd_bit = req.wdata[CCVC_RSVD_BIT];
    end
    if (wr_tvolt)
    begin
      next_temp_voltage_reg = req.wdata;
    end
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      fast_charge_current_reg <= CCVC_RST_FAST_CURRENT;
      temp_current_reg <= CCVC_RST_TEMP_CURRENT;
      fast_charge_voltage <= 6'h00;
      temp_voltage_reg <= CCVC_RST_TEMP_VOLTAGE;
    end
    else if (system_reset)
    begin
      fast_charge_current_reg <= CCVC_RST_FAST_CURRENT;
      temp_current_reg <= CCVC_RST_TEMP_CURRENT;
      fast_charge_voltage <= 6'h00;
      temp_voltage_reg <= CCVC_RST_TEMP_VOLTAGE;
    end
    else
    begin
      fast_charge_current_reg <= next_fast_charge_current_reg;
      temp_current_reg <= next_temp_current_reg;
      fast_charge_voltage <= next_fast_charge_voltage;
      temp_voltage_reg <= next_temp_voltage_reg;
    end
  end

  // charger power-on domain
  // A system reset alone leaves the suspend choice in place on purpose.
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      input_suspend <= 1'b0;
      rsvd_bit <= 1'b0;
    end
    else if (charger_power_on_reset)
    begin
      input_suspend <= 1'b0;
      rsvd_bit <= 1'b0;
    end
    else
    begin
      input_suspend <= next_input_suspend;
      rsvd_bit <= next_rsvd_bit;
    end
  end

  // -------------------------------------------------------------
  // Read path and status
  // -------------------------------------------------------------
  always_comb
  begin
    next_rvalid = req.rd;
    next_rdata = rdata;
    if (req.rd)
    begin
      unique case (req.addr)
        CCVC_ADDR_FAST_CURRENT: next_rdata = fast_charge_current_reg;
        CCVC_ADDR_TEMP_CURRENT: next_rdata = temp_current_reg;
        // bit 0 reads back stored value
        CCVC_ADDR_VOLT_SUSPEND:
          next_rdata = {fast_charge_voltage, input_suspend, rsvd_bit};
        CCVC_ADDR_TEMP_VOLTAGE: next_rdata = temp_voltage_reg;
        default: next_rdata = 8'h00;
      endcase
    end
    next_input_change_interrupt = next_input_suspend && !input_suspend
      && !charger_power_on_reset;
    if (input_suspend)
    begin
      next_input_detail_status = CCVC_INPUT_DETAIL_OFF;
    end
    else
    begin
      next_input_detail_status = input_detail_raw;
    end
    next_temp_qualified = thermistor_enable
      && (cool_threshold || warm_threshold);
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      rdata <= 8'h00;
      rvalid <= 1'b0;
      input_change_interrupt <= 1'b0;
      input_detail_status <= CCVC_INPUT_DETAIL_OFF;
      temp_qualified <= 1'b0;
    end
    else
    begin
      rdata <= next_rdata;
      rvalid <= next_rvalid;
      input_change_interrupt <= next_input_change_interrupt;
      input_detail_status <= next_input_detail_status;
      temp_qualified <= next_temp_qualified;
    end
  end

  // -------------------------------------------------------------
  // Charger drive
  // -------------------------------------------------------------
  assign temp_region = temp_qualified;

  always_comb
  begin
    // compensated current when cool or warm
    if (temp_region)
    begin
      sel_current_code = temp_current_reg[CCVC_CODE_MSB:CCVC_CODE_LSB];
    end
    else
    begin
      sel_current_code =
        fast_charge_current_reg[CCVC_CODE_MSB:CCVC_CODE_LSB];
    end
    // compensated voltage when cool or warm
    if (temp_region)
    begin
      sel_voltage_code = temp_voltage_reg[CCVC_CODE_MSB:CCVC_CODE_LSB];
    end
    else
    begin
      sel_voltage_code = fast_charge_voltage;
    end
  end

  ccvc_code_map u_current_map (
    .core_clk(core_clk),
    .rst(rst),
    .code(sel_current_code),
    .current_0p1ma(map_current),
    .voltage_mv()
  );

  ccvc_code_map u_voltage_map (
    .core_clk(core_clk),
    .rst(rst),
    .code(sel_voltage_code),
    .current_0p1ma(),
    .voltage_mv(map_voltage)
  );

  // input suspended when set
  // Current and voltage are registered in the map instances and again here; bias and suspend only here.
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      drive <= '0;
    end
    else
    begin
      drive.current_0p1ma <= map_current;
      drive.voltage_mv <= map_voltage;
      drive.thermistor_bias <= thermistor_enable;
      drive.input_suspend <= input_suspend;
    end
  end

endmodule

`default_nettype wire

//--- testbench/ccvc_regs_props.sv
`timescale 1ns/1ns
`default_nettype none

module ccvc_regs_props
  import ccvc_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire ccvc_req_t req,
  input wire logic [7:0] rdata,
  input wire logic rvalid,
  input wire logic input_change_interrupt,
  input wire logic [1:0] input_detail_status,
  input wire ccvc_drive_t drive
);
  // ----------------------------------------------------------
  // Port relations
  // ----------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence s_irq;
    input_change_interrupt;
  endsequence
  sequence s_held;
    drive.input_suspend && input_detail_status == 2'h0;
  endsequence
  chk_irq_suspend: assert property (s_irq |=> s_held)
    else $error("suspend missing after interrupt");
  chk_irq_pulse: assert property (s_irq |=> !input_change_interrupt)
    else $error("interrupt longer than one cycle");
  chk_irq_cause: assert property ($rose(drive.input_suspend) |->
    $past(input_change_interrupt)) else $error("suspend without interrupt");
  chk_detail_forced: assert property (drive.input_suspend |->
    input_detail_status == 2'h0) else $error("detail not forced");
  chk_read_answer: assert property (req.rd |=> rvalid)
    else $error("read not answered");
  chk_rdata_hold: assert property (!req.rd |=> $stable(rdata))
    else $error("read data moved");
  chk_current_step: assert property (drive.current_0p1ma % 75 == 0 &&
    drive.current_0p1ma <= CCVC_CURRENT_MAX) else $error("bad current");
  chk_volt_step: assert property (drive.voltage_mv % 25 == 0 &&
    drive.voltage_mv <= CCVC_VOLT_MAX) else $error("bad voltage");
endmodule

`default_nettype wire

//--- testbench/ccvc_host_model.sv
`timescale 1ns/1ns
`default_nettype none

module ccvc_host_model
  import ccvc_pkg::*;
(
  input wire logic core_clk,
  output var ccvc_req_t req
);
  initial req = '0;
  // regulation margin host-side
  // The system rail is set outside this block, so the host keeps its margin.
  task automatic access(input logic w, input logic [7:0] a,
                        input logic [7:0] d);
    logic [7:0] dd;
    dd = d;
    if (w && (a == CCVC_ADDR_TEMP_CURRENT || a == CCVC_ADDR_VOLT_SUSPEND))
      dd[0] = 1'b0;
    @(posedge core_clk);
    req <= '{wr: w, rd: !w, addr: a, wdata: dd};
  endtask
  task automatic idle();
    @(posedge core_clk);
    req <= '0;
  endtask
endmodule

`default_nettype wire

//--- testbench/charger_current_voltage_config_bench.sv
`timescale 1ns/1ns
`default_nettype none

module charger_current_voltage_config_bench
  import ccvc_pkg::*;
();
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic system_reset = 1'b0;
  logic charger_power_on_reset = 1'b0;
  logic cool_threshold = 1'b0;
  logic warm_threshold = 1'b0;
  logic [1:0] input_detail_raw = 2'h0;
  ccvc_req_t req;
  logic [7:0] rdata;
  logic rvalid, input_change_interrupt, temp_qualified;
  logic [1:0] input_detail_status;
  ccvc_drive_t drive;
  int failures = 0;
  int num_checks = 0;
  int cycles = 0;
  int seed = 32'hBB2824E3;
  logic [7:0] exp_q[$];
  logic [5:0] codes[6];
  logic [1:0] raw;
  ccvc_regs ccvc_regs_inst (.core_clk(core_clk), .rst(rst),
    .system_reset(system_reset),
    .charger_power_on_reset(charger_power_on_reset), .req(req),
    .cool_threshold(cool_threshold), .warm_threshold(warm_threshold),
    .input_detail_raw(input_detail_raw), .rdata(rdata), .rvalid(rvalid),
    .input_change_interrupt(input_change_interrupt),
    .input_detail_status(input_detail_status),
    .temp_qualified(temp_qualified), .drive(drive));
  ccvc_host_model ccvc_host_model_inst (.core_clk(core_clk), .req(req));
  always #5 core_clk = ~core_clk;
  // ----------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------
  function automatic int cur(input logic [5:0] k);
    return ((k > 6'h27) ? 40 : k + 1) * 75;
  endfunction
  function automatic int volt(input logic [5:0] k);
    return 3600 + ((k > 6'h28) ? 40 : k) * 25;
  endfunction
  task automatic check(input logic [15:0] got, input logic [15:0] want);
    num_checks++;
    if (got !== want)
    begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    ccvc_host_model_inst.access(1'b0, a, 8'h00);
  endtask
  // Each write ends idle, so two writes never clash in one time step.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    ccvc_host_model_inst.access(1'b1, a, d);
    ccvc_host_model_inst.idle();
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic close_out();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  always @(negedge core_clk)
    if (rvalid === 1'b1)
      check(16'(rdata), exp_q.size() ? 16'(exp_q.pop_front()) : 16'hFFFF);
  always @(posedge core_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      failures++;
      close_out();
    end
  end
  // ----------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------
  initial
  begin
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    rd(CCVC_ADDR_TEMP_CURRENT, 8'h04);
    rd(CCVC_ADDR_VOLT_SUSPEND, 8'h00);
    rd(CCVC_ADDR_FAST_CURRENT, 8'h05);
    rd(8'h30, 8'h00);
    ccvc_host_model_inst.idle();
    $display("test reset done");
    codes = '{6'h00, 6'h26, 6'h27, 6'h28, 6'h3F, 6'h00};
    codes[5] = 6'($random(seed));
    foreach (codes[i])
    begin
      wr(CCVC_ADDR_FAST_CURRENT, {codes[i], 2'b00});
      wr(CCVC_ADDR_VOLT_SUSPEND, {codes[i], 2'b00});
      step(3);
      check(16'(drive.current_0p1ma), 16'(cur(codes[i])));
      check(16'(drive.voltage_mv), 16'(volt(codes[i])));
    end
    $display("test coding done");
    wr(CCVC_ADDR_FAST_CURRENT, 8'h40);
    wr(CCVC_ADDR_VOLT_SUSPEND, 8'h20);
    wr(CCVC_ADDR_TEMP_VOLTAGE, 8'h80);
    for (int m = 0; m < 4; m++)
    begin
      bit q;
      q = (m == 1 || m == 2);
      @(posedge core_clk);
      cool_threshold <= (m < 2);
      warm_threshold <= (m == 2);
      wr(CCVC_ADDR_TEMP_CURRENT, {6'h03, m != 0, 1'b1});
      step(3);
      check(16'(temp_qualified), 16'(q));
      check(16'(drive.thermistor_bias), 16'(m != 0));
      check(16'(drive.current_0p1ma), 16'(q ? cur(6'h03) : cur(6'h10)));
      check(16'(drive.voltage_mv), 16'(q ? 4400 : 3800));
    end
    $display("test temperature done");
    raw = 2'($random(seed)) | 2'h1;
    @(posedge core_clk);
    input_detail_raw <= raw;
    wr(CCVC_ADDR_VOLT_SUSPEND, 8'h02);
    step(0);
    check(16'(input_change_interrupt), 16'h0001);
    step(1);
    check(16'(input_change_interrupt), 16'h0000);
    check(16'(input_detail_status), 16'h0000);
    check(16'(drive.input_suspend), 16'h0001);
    wr(CCVC_ADDR_VOLT_SUSPEND, 8'h00);
    step(3);
    check(16'(input_detail_status), 16'(raw));
    check(16'(drive.input_suspend), 16'h0000);
    $display("test suspend done");
    wr(CCVC_ADDR_VOLT_SUSPEND, 8'h57);
    wr(CCVC_ADDR_TEMP_CURRENT, 8'hFD);
    wr(8'h31, 8'hFF);
    @(posedge core_clk);
    system_reset <= 1'b1;
    @(posedge core_clk);
    system_reset <= 1'b0;
    rd(CCVC_ADDR_VOLT_SUSPEND, 8'h02);
    rd(CCVC_ADDR_TEMP_CURRENT, 8'h04);
    rd(8'h31, 8'h00);
    ccvc_host_model_inst.idle();
    @(posedge core_clk);
    charger_power_on_reset <= 1'b1;
    @(posedge core_clk);
    charger_power_on_reset <= 1'b0;
    rd(CCVC_ADDR_VOLT_SUSPEND, 8'h00);
    ccvc_host_model_inst.idle();
    step(3);
    check(16'(exp_q.size()), 16'h0000);
    $display("test mixed reset done");
    close_out();
  end
endmodule

bind ccvc_regs ccvc_regs_props ccvc_regs_props_inst (.core_clk(core_clk),
  .rst(rst), .req(req), .rdata(rdata), .rvalid(rvalid),
  .input_change_interrupt(input_change_interrupt),
  .input_detail_status(input_detail_status), .drive(drive));

`default_nettype wire
